// ### include/cscce_pkg.sv
/*
 * shared constants for the core static configuration and bus clock-enable block:
 * register offsets, field positions, reset values and scan chain geometry.
 * assumes a single 20 MHz system clock and a synchronous active-high reset.
 */
package cscce_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] CSCCE_OFS_CONFIG = 5'h00;
    localparam logic [4:0] CSCCE_OFS_VBASE = 5'h04;
    localparam logic [4:0] CSCCE_OFS_CONTROL = 5'h08;
    localparam logic [4:0] CSCCE_OFS_INT_STAT = 5'h0c;
    localparam logic [4:0] CSCCE_OFS_BUS_WDATA = 5'h10;
    localparam logic [4:0] CSCCE_OFS_BUS_RDATA = 5'h14;

    // config register fields
    localparam int CSCCE_CFG_RAM_EN_BIT = 0;
    localparam int CSCCE_CFG_HIVEC_BIT = 1;
    localparam int CSCCE_CFG_BIGEND_BIT = 2;

    // control register fields
    localparam int CSCCE_CTL_BIGEND_BIT = 0;
    localparam int CSCCE_CTL_IRQ_EN_BIT = 1;
    localparam int CSCCE_CTL_FIQ_EN_BIT = 2;
    localparam int CSCCE_CTL_WIDTH = 3;
    localparam logic [2:0] CSCCE_CTL_RESET = 3'h0;

    // interrupt status fields
    localparam int CSCCE_IST_FIQ_BIT = 0;
    localparam int CSCCE_IST_IRQ_BIT = 1;

    // exception vector bases
    localparam logic [31:0] CSCCE_VBASE_LOW = 32'h0000_0000;
    localparam logic [31:0] CSCCE_VBASE_HIGH = 32'hffff_0000;

    // system bus word reset value
    localparam logic [31:0] CSCCE_BUS_RESET = 32'h0000_0000;

    // scan chain geometry
    localparam int CSCCE_SCAN_CHAINS = 4;
    localparam int CSCCE_SCAN_LEN = 8;

endpackage

// ### hw/cscce_strap_latch.sv
/*
 * strap capture: holds the ram-enable and high-vector straps as seen during reset.
 * assumes straps are synchronous to clk_sys and settled while rst is high.
 */
`timescale 1ns/1ps
module cscce_strap_latch (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // straps
    input wire logic ram_enable_strap,
    input wire logic high_vector_strap,
    // captured configuration
    output logic ram_enable,
    output logic high_vector
);
    import cscce_pkg::*;

    logic ram_en_d;
    logic ram_en_q;
    logic hivec_d;
    logic hivec_q;

    always_comb begin
        ram_en_d = ram_en_q;
        hivec_d = hivec_q;
        // RULE_07: capture only in reset
        // RULE_09: vector strap held after reset
        if (rst) begin
            ram_en_d = ram_enable_strap;
            hivec_d = high_vector_strap;
        end
    end

    always_ff @(posedge clk_sys) begin
        ram_en_q <= ram_en_d;
        hivec_q <= hivec_d;
    end

    // RULE_06: both rams follow strap
    assign ram_enable = ram_en_q;
    assign high_vector = hivec_q;
endmodule

// ### hw/cscce_scan_chains.sv
/*
 * four independent serial scan chains, each a shift register of fixed length.
 * assumes scan inputs are synchronous to clk_sys; shifting only while enabled.
 */
`timescale 1ns/1ps
module cscce_scan_chains (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // scan control
    input wire logic shift_en,
    input wire logic [cscce_pkg::CSCCE_SCAN_CHAINS-1:0] scan_in,
    // serial outputs
    output logic [cscce_pkg::CSCCE_SCAN_CHAINS-1:0] scan_out
);
    import cscce_pkg::*;

    logic [CSCCE_SCAN_LEN-1:0] chain_d [CSCCE_SCAN_CHAINS];
    logic [CSCCE_SCAN_LEN-1:0] chain_q [CSCCE_SCAN_CHAINS];

    always_comb begin
        for (int i = 0; i < CSCCE_SCAN_CHAINS; i++) begin
            chain_d[i] = chain_q[i];
            // RULE_13: each chain shifts on its own
            if (rst) begin
                chain_d[i] = '0;
            end else if (shift_en) begin
                chain_d[i] = {chain_q[i][CSCCE_SCAN_LEN-2:0], scan_in[i]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < CSCCE_SCAN_CHAINS; i++) begin
            chain_q[i] <= chain_d[i];
        end
    end

    always_comb begin
        for (int i = 0; i < CSCCE_SCAN_CHAINS; i++) begin
            scan_out[i] = chain_q[i][CSCCE_SCAN_LEN-1];
        end
    end
endmodule

// ### hw/cscce_top.sv
/*
 * core static configuration and bus clock-enable block: strap capture, vector base,
 * endian indicator, active-low interrupt inputs, a qualified system-bus word stage,
 * scan chains and an avalon-mm slave with waitrequest for software access.
 * assumes every input is synchronous to clk_sys and the qualifier is a one-cycle pulse.
 */
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
//
// Function
// RULE_01: the system pulses the bus clock qualifier high for one core clock per slow bus clock edge.
// RULE_02: system-bus outputs of the block change only on a core clock edge where the qualifier is high; reset here clears them on any edge.
// RULE_03: the block keeps working when the core clock is held high or low for a long time.
// RULE_04: both interrupt inputs are active low, a low level meaning a request.
// RULE_05: the interrupt sources drive both request inputs synchronously to the core clock.
// RULE_06: a high ram-enable strap leaves reset with both rams enabled, a low one with both disabled.
// RULE_07: the ram-enable strap is captured only during reset and later changes are ignored.
// RULE_08: the vector base is 0x00000000 for a low high-vector strap and 0xffff0000 for a high one.
// RULE_09: the high-vector strap is sampled only during reset and the resulting base is held.
// RULE_10: the endian indicator is high in big-endian operation and low in little-endian.
// RULE_11: the system keeps the endian setting fixed from reset or changes it by a careful software sequence.
// RULE_12: while scan enable is high the block shifts scan data instead of operating functionally.
// RULE_13: there are four independent scan chains 0 to 3, each with its own input and output.
// RULE_14: system-bus inputs are sampled only on qualified edges and bus state holds otherwise; reset here clears the bus state on any edge.
`timescale 1ns/1ps
module cscce_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // system bus side
    input wire logic bus_clock_qualifier,
    input wire logic [31:0] bus_in_data,
    output logic [31:0] bus_out_data,
    // interrupts
    input wire logic fast_int_req_n,
    input wire logic normal_int_req_n,
    output logic fiq_request,
    output logic irq_request,
    // static configuration
    input wire logic ram_enable_strap,
    input wire logic high_vector_strap,
    output logic iram_enable,
    output logic dram_enable,
    output logic [31:0] vector_base,
    output logic endian_indicator,
    // scan
    input wire logic scan_shift_enable,
    input wire logic scan_in_0,
    input wire logic scan_in_1,
    input wire logic scan_in_2,
    input wire logic scan_in_3,
    output logic scan_out_0,
    output logic scan_out_1,
    output logic scan_out_2,
    output logic scan_out_3
);
    import cscce_pkg::*;

    // byte-lane merge of a write into a held word
    function automatic logic [31:0] cscce_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // word offset of a byte address
    function automatic logic [4:0] cscce_word_ofs(input logic [4:0] a);
        return {a[4:2], 2'b00};
    endfunction

    logic strap_ram_en;
    logic strap_hivec;
    logic [CSCCE_SCAN_CHAINS-1:0] scan_out_w;

    logic ack_d;
    logic ack_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [CSCCE_CTL_WIDTH-1:0] ctl_d;
    logic [CSCCE_CTL_WIDTH-1:0] ctl_q;
    logic [31:0] bus_wdata_d;
    logic [31:0] bus_wdata_q;
    logic [31:0] bus_out_d;
    logic [31:0] bus_out_q;
    logic [31:0] bus_in_d;
    logic [31:0] bus_in_q;
    logic fiq_d;
    logic fiq_q;
    logic irq_d;
    logic irq_q;
    logic fiq_out_d;
    logic fiq_out_q;
    logic irq_out_d;
    logic irq_out_q;
    logic [31:0] vbase_d;
    logic [31:0] vbase_q;
    logic endian_d;
    logic endian_q;
    logic ramen_d;
    logic ramen_q;

    logic func_en;
    logic wr_take;
    logic [4:0] word_ofs;

    cscce_strap_latch u_strap (
        .clk_sys(clk_sys),
        .rst(rst),
        .ram_enable_strap(ram_enable_strap),
        .high_vector_strap(high_vector_strap),
        .ram_enable(strap_ram_en),
        .high_vector(strap_hivec)
    );

    // RULE_13: four chains, own pins
    cscce_scan_chains u_scan (
        .clk_sys(clk_sys),
        .rst(rst),
        .shift_en(scan_shift_enable),
        .scan_in({scan_in_3, scan_in_2, scan_in_1, scan_in_0}),
        .scan_out(scan_out_w)
    );

    // RULE_12: functional state frozen during scan
    assign func_en = ~scan_shift_enable;
    // scan rising in an answer cycle drops that write
    assign wr_take = ack_q & avs_write & func_en;
    assign word_ofs = cscce_word_ofs(avs_address);

    // avalon slave: one wait cycle, answer on the second edge
    always_comb begin
        ack_d = 1'b0;
        rdata_d = rdata_q;
        if (rst) begin
            rdata_d = '0;
        end else if ((avs_read | avs_write) & ~ack_q & func_en) begin
            ack_d = 1'b1;
            rdata_d = '0;
            if (avs_read) begin
                unique case (word_ofs)
                    CSCCE_OFS_CONFIG: begin
                        rdata_d[CSCCE_CFG_RAM_EN_BIT] = ramen_q;
                        rdata_d[CSCCE_CFG_HIVEC_BIT] = strap_hivec;
                        rdata_d[CSCCE_CFG_BIGEND_BIT] = endian_q;
                    end
                    CSCCE_OFS_VBASE: begin
                        rdata_d = vbase_q;
                    end
                    CSCCE_OFS_CONTROL: begin
                        rdata_d[CSCCE_CTL_WIDTH-1:0] = ctl_q;
                    end
                    CSCCE_OFS_INT_STAT: begin
                        rdata_d[CSCCE_IST_FIQ_BIT] = fiq_q;
                        rdata_d[CSCCE_IST_IRQ_BIT] = irq_q;
                    end
                    CSCCE_OFS_BUS_WDATA: begin
                        rdata_d = bus_wdata_q;
                    end
                    CSCCE_OFS_BUS_RDATA: begin
                        rdata_d = bus_in_q;
                    end
                    default: begin
                        rdata_d = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        ack_q <= ack_d;
        rdata_q <= rdata_d;
    end

    // software registers
    always_comb begin
        logic [31:0] ctl_word;
        ctl_word = '0;
        ctl_word[CSCCE_CTL_WIDTH-1:0] = ctl_q;
        ctl_d = ctl_q;
        bus_wdata_d = bus_wdata_q;
        if (rst) begin
            ctl_d = CSCCE_CTL_RESET;
            bus_wdata_d = CSCCE_BUS_RESET;
        end else if (wr_take) begin
            if (word_ofs == CSCCE_OFS_CONTROL) begin
                ctl_word = cscce_merge(ctl_word, avs_writedata, avs_byteenable);
                ctl_d = ctl_word[CSCCE_CTL_WIDTH-1:0];
            end
            if (word_ofs == CSCCE_OFS_BUS_WDATA) begin
                bus_wdata_d = cscce_merge(bus_wdata_q, avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        ctl_q <= ctl_d;
        bus_wdata_q <= bus_wdata_d;
    end

    // qualified system-bus stage
    always_comb begin
        bus_out_d = bus_out_q;
        bus_in_d = bus_in_q;
        if (rst) begin
            // reset clears the word off a qualified edge
            bus_out_d = CSCCE_BUS_RESET;
            bus_in_d = CSCCE_BUS_RESET;
        end else if (bus_clock_qualifier & func_en) begin
            // RULE_01: one pulse per slow bus edge
            // RULE_02: outputs move on qualified edge
            bus_out_d = bus_wdata_q;
            // RULE_14: inputs sampled when qualified
            bus_in_d = bus_in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        bus_out_q <= bus_out_d;
        bus_in_q <= bus_in_d;
    end

    // interrupt inputs
    always_comb begin
        fiq_d = fiq_q;
        irq_d = irq_q;
        fiq_out_d = fiq_out_q;
        irq_out_d = irq_out_q;
        if (rst) begin
            fiq_d = 1'b0;
            irq_d = 1'b0;
            fiq_out_d = 1'b0;
            irq_out_d = 1'b0;
        end else if (func_en) begin
            // RULE_05: inputs used without synchroniser
            // RULE_04: low level is a request
            fiq_d = ~fast_int_req_n;
            irq_d = ~normal_int_req_n;
            // no latching: a request drops on the first clock edge after its pin rises
            fiq_out_d = ~fast_int_req_n & ctl_q[CSCCE_CTL_FIQ_EN_BIT];
            irq_out_d = ~normal_int_req_n & ctl_q[CSCCE_CTL_IRQ_EN_BIT];
        end
    end

    // RULE_03: purely edge driven, no timers
    always_ff @(posedge clk_sys) begin
        fiq_q <= fiq_d;
        irq_q <= irq_d;
        fiq_out_q <= fiq_out_d;
        irq_out_q <= irq_out_d;
    end

    // configuration outputs
    always_comb begin
        vbase_d = vbase_q;
        endian_d = endian_q;
        ramen_d = ramen_q;
        if (rst) begin
            vbase_d = CSCCE_VBASE_LOW;
            endian_d = 1'b0;
            ramen_d = 1'b0;
        end else if (func_en) begin
            // RULE_08: base from captured strap
            vbase_d = strap_hivec ? CSCCE_VBASE_HIGH : CSCCE_VBASE_LOW;
            // RULE_10: indicator high when big-endian
            // RULE_11: software owns the endian change
            endian_d = ctl_q[CSCCE_CTL_BIGEND_BIT];
            // RULE_06: rams follow captured strap
            ramen_d = strap_ram_en;
        end
    end

    // base and ram enables only move in reset and at reset release
    always_ff @(posedge clk_sys) begin
        vbase_q <= vbase_d;
        endian_q <= endian_d;
        ramen_q <= ramen_d;
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = ~ack_q;
    assign bus_out_data = bus_out_q;
    assign fiq_request = fiq_out_q;
    assign irq_request = irq_out_q;
    assign iram_enable = ramen_q;
    assign dram_enable = ramen_q;
    assign vector_base = vbase_q;
    assign endian_indicator = endian_q;
    assign scan_out_0 = scan_out_w[0];
    assign scan_out_1 = scan_out_w[1];
    assign scan_out_2 = scan_out_w[2];
    assign scan_out_3 = scan_out_w[3];
endmodule

// ### tb/cscce_checker.sv
/*
 checker for the static configuration, qualifier and scan relations.
 assumes the ports of cscce_top and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cscce_checker
import cscce_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon slave
    input wire logic [4:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // system bus and interrupts
    input wire logic bus_clock_qualifier,
    input wire logic [31:0] bus_out_data,
    input wire logic fast_int_req_n,
    input wire logic normal_int_req_n,
    input wire logic fiq_request,
    input wire logic irq_request,
    // configuration and scan
    input wire logic ram_enable_strap,
    input wire logic high_vector_strap,
    input wire logic iram_enable,
    input wire logic dram_enable,
    input wire logic [31:0] vector_base,
    input wire logic endian_indicator,
    input wire logic scan_shift_enable,
    input wire logic scan_in_0,
    input wire logic scan_out_0
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_bus_hold; !bus_clock_qualifier |=> $stable(bus_out_data); endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus word moved off qualifier");
    property p_fiq_idle; !scan_shift_enable && fast_int_req_n |=> !fiq_request; endproperty
    a_fiq_idle: assert property (p_fiq_idle) else $error("fast request without low input");
    property p_irq_idle; !scan_shift_enable && normal_int_req_n |=> !irq_request; endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("normal request without low input");
    property p_ram_cap;
        $fell(rst) |=> iram_enable == $past(ram_enable_strap, 2) && dram_enable == iram_enable;
    endproperty
    a_ram_cap: assert property (p_ram_cap) else $error("ram enables differ from strap");
    property p_ram_hold;
        !$past(rst) && !$past(rst, 2) |-> $stable(iram_enable) && $stable(dram_enable);
    endproperty
    a_ram_hold: assert property (p_ram_hold) else $error("ram enable moved after reset");
    property p_vb_cap;
        $fell(rst) |=> vector_base == ($past(high_vector_strap, 2) ? CSCCE_VBASE_HIGH : CSCCE_VBASE_LOW);
    endproperty
    a_vb_cap: assert property (p_vb_cap) else $error("vector base differs from strap");
    property p_vb_hold; !$past(rst) && !$past(rst, 2) |-> $stable(vector_base); endproperty
    a_vb_hold: assert property (p_vb_hold) else $error("vector base moved after reset");
    property p_endian;
        avs_write && !avs_waitrequest && avs_address[4:2] == 3'h2 && avs_byteenable[0] && !scan_shift_enable
            |-> ##2 endian_indicator == $past(avs_writedata[0], 2);
    endproperty
    a_endian: assert property (p_endian) else $error("endian indicator not as written");
    property p_scan0; scan_shift_enable [*8] |=> scan_out_0 == $past(scan_in_0, 8); endproperty
    a_scan0: assert property (p_scan0) else $error("scan chain 0 output wrong");
    c_qual: cover property (bus_clock_qualifier);
    c_fiq: cover property (fiq_request);
    c_scan: cover property (scan_shift_enable [*8]);
endmodule

bind cscce_top cscce_checker u_chk(.clk_sys, .rst, .avs_address, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_waitrequest, .bus_clock_qualifier, .bus_out_data, .fast_int_req_n,
    .normal_int_req_n, .fiq_request, .irq_request, .ram_enable_strap, .high_vector_strap,
    .iram_enable, .dram_enable, .vector_base, .endian_indicator, .scan_shift_enable,
    .scan_in_0, .scan_out_0);

// ### tb/cscce_sys_model.sv
/*
 system glue partner: makes the bus clock qualifier and the bus input word.
 assumes run is driven synchronously to clk_sys.
*/
`timescale 1ns/1ps
module cscce_sys_model #(
    parameter int DIV = 4
) (
    // clock, reset and enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    // system bus side
    output logic bus_clock_qualifier,
    output logic [31:0] bus_in_data
);
    logic [7:0] cnt_q;
    initial begin
        cnt_q = 8'h0;
        bus_clock_qualifier = 1'b0;
        bus_in_data = 32'h5a5a_0000;
    end
    // one core clock high per slow edge
    always @(posedge clk_sys) begin
        if (rst || !run) begin
            cnt_q <= 8'h0;
            bus_clock_qualifier <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == DIV - 1) ? 8'h0 : cnt_q + 8'h1;
            bus_clock_qualifier <= (cnt_q == DIV - 1);
        end
    end
    // word moves every core clock, harsher than a real slow bus
    always @(posedge clk_sys) bus_in_data <= bus_in_data + 32'h0101_0101;
endmodule

// ### tb/cscce_top_tb.sv
/*
 self-checking bench for cscce_top with the system glue model.
 assumes the one-wait avalon answer and one-cycle latencies of the hand-over.
*/
`timescale 1ns/1ps
module cscce_top_tb;
    import cscce_pkg::*;
    logic clk_sys = 0, rst = 1, stretch = 0, run = 0;
    logic [4:0] avs_address = 0;
    logic avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, bus_in_data, bus_out_data, vector_base, rd, bin;
    logic [3:0] avs_byteenable = 4'hf, si = 0;
    wire [3:0] so;
    logic avs_waitrequest, bus_clock_qualifier, fiq_request, irq_request;
    logic iram_enable, dram_enable, endian_indicator;
    logic fast_int_req_n = 1, normal_int_req_n = 1, ram_enable_strap = 0, high_vector_strap = 0;
    logic scan_shift_enable = 0;
    logic [15:0] pat [4] = '{16'ha5c3, 16'h3c5a, 16'hf00f, 16'h0ff0};
    int n_fail = 0, cmp_count = 0;
    initial forever begin
        #25;
        if (!stretch) clk_sys = ~clk_sys;
    end
    cscce_top u_dut(.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_clock_qualifier, .bus_in_data,
        .bus_out_data, .fast_int_req_n, .normal_int_req_n, .fiq_request, .irq_request,
        .ram_enable_strap, .high_vector_strap, .iram_enable, .dram_enable, .vector_base,
        .endian_indicator, .scan_shift_enable, .scan_in_0(si[0]), .scan_in_1(si[1]),
        .scan_in_2(si[2]), .scan_in_3(si[3]), .scan_out_0(so[0]), .scan_out_1(so[1]),
        .scan_out_2(so[2]), .scan_out_3(so[3]));
    cscce_sys_model #(.DIV(4)) u_sys(.clk_sys, .rst, .run, .bus_clock_qualifier, .bus_in_data);
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, avs_waitrequest}, 32'h0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk_sys);
    endtask
    task rst_dut(input logic r, input logic h);
        rst <= 1;
        ram_enable_strap <= r;
        high_vector_strap <= h;
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        repeat (2) @(posedge clk_sys);
    endtask
    task t_straps;
        for (int i = 0; i < 4; i++) begin
            rst_dut(i[0], i[1]);
            chk({31'h0, iram_enable}, {31'h0, i[0]});
            chk({31'h0, dram_enable}, {31'h0, i[0]});
            chk(vector_base, i[1] ? CSCCE_VBASE_HIGH : CSCCE_VBASE_LOW);
            ram_enable_strap <= !i[0];
            high_vector_strap <= !i[1];
            repeat (3) @(posedge clk_sys);
            av(0, CSCCE_OFS_CONFIG, 0);
            chk(rd & 32'h3, {30'h0, i[1], i[0]});
            chk(vector_base, i[1] ? CSCCE_VBASE_HIGH : CSCCE_VBASE_LOW);
            av(0, CSCCE_OFS_VBASE, 0);
            chk(rd, i[1] ? CSCCE_VBASE_HIGH : CSCCE_VBASE_LOW);
        end
        $display("strap test done");
    endtask
    task t_endian;
        av(1, CSCCE_OFS_CONTROL, 32'h1);
        @(posedge clk_sys);
        chk({31'h0, endian_indicator}, 32'h1);
        av(1, CSCCE_OFS_CONTROL, 32'h0);
        @(posedge clk_sys);
        chk({31'h0, endian_indicator}, 32'h0);
        av(0, 5'h18, 0);
        chk(rd, 32'h0);
        av(1, CSCCE_OFS_BUS_WDATA, 32'h1122_3344);
        avs_byteenable <= 4'h6;
        av(1, CSCCE_OFS_BUS_WDATA, 32'haabb_ccdd);
        avs_byteenable <= 4'hf;
        av(0, CSCCE_OFS_BUS_WDATA, 0);
        chk(rd, 32'h11bb_cc44);
        $display("endian test done");
    endtask
    task t_irq;
        av(1, CSCCE_OFS_CONTROL, 32'h6);
        fast_int_req_n <= 0;
        repeat (2) @(posedge clk_sys);
        chk({30'h0, irq_request, fiq_request}, 32'h1);
        av(0, CSCCE_OFS_INT_STAT, 0);
        chk(rd, 32'h1);
        fast_int_req_n <= 1;
        normal_int_req_n <= 0;
        repeat (2) @(posedge clk_sys);
        chk({30'h0, irq_request, fiq_request}, 32'h2);
        av(1, CSCCE_OFS_CONTROL, 32'h0);
        @(posedge clk_sys);
        chk({30'h0, irq_request, fiq_request}, 32'h0);
        normal_int_req_n <= 1;
        $display("interrupt test done");
    endtask
    task t_bus;
        int n;
        n = 0;
        av(1, CSCCE_OFS_BUS_WDATA, 32'h1234_abcd);
        chk(bus_out_data, CSCCE_BUS_RESET);
        run <= 1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (bus_clock_qualifier !== 1'b1 && n < 20);
        chk({31'h0, bus_clock_qualifier}, 32'h1);
        bin = bus_in_data;
        run <= 0;
        @(posedge clk_sys);
        chk(bus_out_data, 32'h1234_abcd);
        stretch = 1;
        #1000;
        stretch = 0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        stretch = 1;
        #1000;
        stretch = 0;
        @(posedge clk_sys);
        av(0, CSCCE_OFS_BUS_RDATA, 0);
        chk(rd, bin);
        chk(bus_out_data, 32'h1234_abcd);
        $display("bus test done");
    endtask
    task t_scan;
        scan_shift_enable <= 1;
        for (int i = 0; i < 16; i++) begin
            for (int c = 0; c < 4; c++) si[c] <= pat[c][i];
            @(posedge clk_sys);
            if (i >= 8) chk({28'h0, so}, {28'h0, pat[3][i-8], pat[2][i-8], pat[1][i-8], pat[0][i-8]});
        end
        scan_shift_enable <= 0;
        @(posedge clk_sys);
        $display("scan test done");
    endtask
    initial begin
        t_straps;
        t_endian;
        t_irq;
        t_bus;
        t_scan;
        results;
    end
    initial begin
        #(2000 * 50);
        n_fail++;
        results;
    end
endmodule
